// *** design/pll_reconfig.sv ***
// Settings chain, apply logic, phase stepper and APB registers
//
// Summary of operation
// - Chain holds exactly 144 setting bits
// - Counters 16 bits; pump, filter 9 each
// - Each counter segment adds skip, halfcycle
// - First shifted bit: counter four low LSB
// - Last shifted bit: filter setting MSB
// - Pump code only 0, 1, 3, 7
// - Resistor code only listed eleven values
// - Capacitor code only 0, 1, 3
// - Skip bit set ignores segment's other bits
// - Skipped counter divides by one
// - Phase step moves tap, chain untouched
// - One step is one eighth period
// - Output clocks keep running while stepping
// - Target select decode, registered on rising
// - Direction high forward, low backward
// - Request sampled on falling edge, held two
// - Second rising edge captures, starts step
// - Complete falls there, rises when done
// - One step per pulse, pulses spaced
// - Apply pulse loads chain into configuration
// - Apply busy flag falls when loaded
// - Count splits high/low; halfcycle moves half
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pll_reconfig
  import pll_reconfig_pkg::*;
(
  // Clock, reset, freeze
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reconfiguration link
  input wire link_in_s link,
  output logic phase_step_complete,
  output logic apply_in_progress,
  // Counter state toward the synthesiser
  output logic [NUM_TAPS-1:0][TAP_BITS-1:0] phase_tap,
  output cnt_eff_s [NUM_SEGS-1:0] counter_eff
);

  function automatic cnt_eff_s eff_f(input logic [SEG_BITS-1:0] seg);
    cnt_eff_s e;
    e.bypass = seg[SEG_SKIP];
    if (seg[SEG_SKIP]) begin
      e.high_half = 9'h001;
      e.low_half = 9'h001;
    end else begin
      e.high_half = {seg[SEG_HIGH_LSB +: CNT_BITS], 1'b0}
                    - {8'h00, seg[SEG_HALF]};
      e.low_half = {seg[SEG_LOW_LSB +: CNT_BITS], 1'b0}
                   + {8'h00, seg[SEG_HALF]};
    end
    return e;
  endfunction : eff_f

  function automatic logic codes_ok_f(input logic [CHAIN_BITS-1:0] c);
    logic ok;
    ok = 1'b1;
    case (c[PUMP_LSB +: PUMP_BITS])
      3'h0, 3'h1, 3'h3, 3'h7: ;
      default: ok = 1'b0;
    endcase
    case (c[FILT_RES_LSB +: FILT_RES_BITS])
      5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14, 5'h18, 5'h1b,
      5'h1c, 5'h1e: ;
      default: ok = 1'b0;
    endcase
    case (c[FILT_CAP_LSB +: FILT_CAP_BITS])
      2'h0, 2'h1, 2'h3: ;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction : codes_ok_f

  function automatic logic tap_sel_f(input logic [2:0] tgt, input int idx);
    logic hit;
    hit = 1'b0;
    if (idx == TAP_FB) begin
      hit = (tgt == TGT_FB);
    end else begin
      hit = (tgt == TGT_ALL) || (tgt == 3'(TGT_C0 + idx));
    end
    return hit;
  endfunction : tap_sel_f

  // Pin synchroniser, the third stage lines data up with the clock edge
  link_in_s sync1_q, sync2_q, sync3_q;
  logic rise_evt, fall_evt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else if (ce) begin
      sync1_q <= link;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  // Data taken from stage three was sampled before the detected edge
  assign rise_evt = sync2_q.recfg_clk & ~sync3_q.recfg_clk;
  assign fall_evt = ~sync2_q.recfg_clk & sync3_q.recfg_clk;

  // Settings chain and apply
  logic [CHAIN_BITS-1:0] chain_q, chain_d, cfg_q, cfg_d;
  logic apply_seen_q, apply_seen_d, apply_evt;
  logic apply_in_progress_d, code_err_q, code_err_d;
  logic [7:0] apply_cnt_q, apply_cnt_d;
  cnt_eff_s [NUM_SEGS-1:0] eff_all, counter_eff_d;
  logic [7:0] apply_cycles_q, step_cycles_q;

  for (genvar s = 0; s < NUM_SEGS; s++) begin : g_eff
    assign eff_all[s] = eff_f(cfg_q[s*SEG_BITS +: SEG_BITS]);
  end

  assign apply_evt = rise_evt & sync3_q.apply_settings & ~apply_seen_q;

  always_comb begin
    chain_d = chain_q;
    cfg_d = cfg_q;
    apply_seen_d = apply_seen_q;
    apply_in_progress_d = apply_in_progress;
    apply_cnt_d = apply_cnt_q;
    code_err_d = code_err_q;
    counter_eff_d = counter_eff;
    if (rise_evt && sync3_q.shift_enable) begin
      // New bit enters at the top; after 144 shifts bit 0 is the first
      chain_d = {sync3_q.serial_setting_in, chain_q[CHAIN_BITS-1:1]};
    end
    if (rise_evt) begin
      apply_seen_d = sync3_q.apply_settings;
    end
    if (apply_evt) begin
      cfg_d = chain_q;
      apply_in_progress_d = 1'b1;
      apply_cnt_d = apply_cycles_q;
      code_err_d = ~codes_ok_f(chain_q);
    end else if (apply_in_progress) begin
      if (apply_cnt_q == 8'h00) begin
        counter_eff_d = eff_all;
        apply_in_progress_d = 1'b0;
      end else begin
        apply_cnt_d = apply_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_q <= '0;
      cfg_q <= '0;
      apply_seen_q <= 1'b0;
      apply_in_progress <= 1'b0;
      apply_cnt_q <= 8'h00;
      code_err_q <= 1'b0;
      counter_eff <= '0;
    end else if (ce) begin
      chain_q <= chain_d;
      cfg_q <= cfg_d;
      apply_seen_q <= apply_seen_d;
      apply_in_progress <= apply_in_progress_d;
      apply_cnt_q <= apply_cnt_d;
      code_err_q <= code_err_d;
      counter_eff <= counter_eff_d;
    end
  end

  // Phase stepper; taps move only, clocks never stop
  phase_state_e ph_q, ph_d;
  logic armed_q, armed_d, dir_q, dir_d, complete_d;
  logic [2:0] tgt_q, tgt_d;
  logic [7:0] step_cnt_q, step_cnt_d;
  logic [NUM_TAPS-1:0][TAP_BITS-1:0] phase_tap_d;

  always_comb begin
    ph_d = ph_q;
    armed_d = armed_q;
    dir_d = dir_q;
    tgt_d = tgt_q;
    step_cnt_d = step_cnt_q;
    complete_d = phase_step_complete;
    phase_tap_d = phase_tap;
    // A pulse must be seen low once before it can start another step
    if (fall_evt && !sync3_q.phase_step_request) begin
      armed_d = 1'b1;
    end
    case (ph_q)
      PH_IDLE: begin
        if (fall_evt && sync3_q.phase_step_request && armed_q) begin
          ph_d = PH_WAIT1;
          armed_d = 1'b0;
        end
      end
      PH_WAIT1: begin
        if (rise_evt) begin
          ph_d = PH_WAIT2;
        end
      end
      PH_WAIT2: begin
        if (rise_evt) begin
          dir_d = sync3_q.phase_direction;
          tgt_d = sync3_q.phase_target_select;
          complete_d = 1'b0;
          step_cnt_d = step_cycles_q;
          ph_d = PH_BUSY;
        end
      end
      PH_BUSY: begin
        if (step_cnt_q == 8'h00) begin
          for (int i = 0; i < NUM_TAPS; i++) begin
            if (tap_sel_f(tgt_q, i)) begin
              // One of eight taps per VCO period, wraps around
              phase_tap_d[i] = dir_q ? phase_tap[i] + 3'h1
                                     : phase_tap[i] - 3'h1;
            end
          end
          complete_d = 1'b1;
          ph_d = PH_IDLE;
        end else begin
          step_cnt_d = step_cnt_q - 8'h01;
        end
      end
      default: ph_d = PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph_q <= PH_IDLE;
      armed_q <= 1'b0;
      dir_q <= 1'b0;
      tgt_q <= 3'h0;
      step_cnt_q <= 8'h00;
      phase_step_complete <= 1'b1;
      phase_tap <= '0;
    end else if (ce) begin
      ph_q <= ph_d;
      armed_q <= armed_d;
      dir_q <= dir_d;
      tgt_q <= tgt_d;
      step_cnt_q <= step_cnt_d;
      phase_step_complete <= complete_d;
      phase_tap <= phase_tap_d;
    end
  end

  // APB slave with one wait state so that read data is registered
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d;
  logic [7:0] apply_cycles_d, step_cycles_d;
  logic acc_first, acc_done;

  assign acc_first = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;

  always_comb begin
    prdata_d = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d = acc_first;
    apply_cycles_d = apply_cycles_q;
    step_cycles_d = step_cycles_q;
    if (acc_first) begin
      case (paddr)
        ADDR_CTRL: prdata_d = {16'h0000, step_cycles_q, apply_cycles_q};
        ADDR_STATUS: prdata_d = {28'h0000000, sync3_q.shift_enable,
                                 code_err_q, phase_step_complete,
                                 apply_in_progress};
        ADDR_TAPS: prdata_d = {14'h0000, phase_tap};
        ADDR_CFG0: prdata_d = cfg_q[31:0];
        ADDR_CFG1: prdata_d = cfg_q[63:32];
        ADDR_CFG2: prdata_d = cfg_q[95:64];
        ADDR_CFG3: prdata_d = cfg_q[127:96];
        ADDR_CFG4: prdata_d = {16'h0000, cfg_q[143:128]};
        default: pslverr_d = 1'b1;
      endcase
    end
    // Writes land only at the edge that completes the access
    if (acc_done && pwrite && paddr == ADDR_CTRL) begin
      apply_cycles_d = pwdata[CTRL_APPLY_LSB +: 8];
      step_cycles_d = pwdata[CTRL_STEP_LSB +: 8];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      apply_cycles_q <= APPLY_CYCLES_RST;
      step_cycles_q <= STEP_CYCLES_RST;
    end else if (ce) begin
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      apply_cycles_q <= apply_cycles_d;
      step_cycles_q <= step_cycles_d;
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_step_end;
    ce && ph_q == PH_BUSY && step_cnt_q == 8'h00;
  endsequence

  property p_shift;
    (ce && rise_evt && sync3_q.shift_enable) |=>
      chain_q[CHAIN_BITS-1] == $past(sync3_q.serial_setting_in) &&
      chain_q[CHAIN_BITS-2:0] == $past(chain_q[CHAIN_BITS-1:1]);
  endproperty
  a_shift: assert property (p_shift) else $error("chain shift wrong");

  property p_apply_load;
    (ce && apply_evt) |=> apply_in_progress && cfg_q == $past(chain_q);
  endproperty
  a_apply_load: assert property (p_apply_load) else $error("apply load");

  property p_apply_done;
    $fell(apply_in_progress) |-> counter_eff == eff_all;
  endproperty
  a_apply_done: assert property (p_apply_done) else $error("apply end");

  property p_bypass;
    counter_eff[SEG_PRE].bypass |->
      counter_eff[SEG_PRE].high_half == 9'h001 &&
      counter_eff[SEG_PRE].low_half == 9'h001;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass div");

  property p_sample_fall;
    (ce && ph_q == PH_IDLE && !fall_evt) |=> ph_q == PH_IDLE;
  endproperty
  a_sample_fall: assert property (p_sample_fall) else $error("sample");

  property p_complete_low;
    (ce && ph_q == PH_WAIT2 && rise_evt) |=>
      !phase_step_complete && ph_q == PH_BUSY;
  endproperty
  a_complete_low: assert property (p_complete_low) else $error("low");

  property p_fb_step;
    (s_step_end and (tgt_q == TGT_FB)) |=>
      phase_tap[TAP_FB] == 3'($past(phase_tap[TAP_FB]) +
                              ($past(dir_q) ? 3'h1 : 3'h7)) &&
      phase_step_complete;
  endproperty
  a_fb_step: assert property (p_fb_step) else $error("fb tap step");

  property p_all_step;
    (s_step_end and (tgt_q == TGT_ALL)) |=>
      phase_tap[0] == 3'($past(phase_tap[0]) +
                         ($past(dir_q) ? 3'h1 : 3'h7)) &&
      $stable(phase_tap[TAP_FB]);
  endproperty
  a_all_step: assert property (p_all_step) else $error("all step");

  property p_tap_hold;
    (ce && !(ph_q == PH_BUSY && step_cnt_q == 8'h00)) |=>
      $stable(phase_tap);
  endproperty
  a_tap_hold: assert property (p_tap_hold) else $error("stray tap");

  property p_complete_rise;
    $rose(phase_step_complete) |-> $past(ph_q) == PH_BUSY && ph_q == PH_IDLE;
  endproperty
  a_complete_rise: assert property (p_complete_rise) else $error("rise");

endmodule : pll_reconfig

`default_nettype wire

// *** design/pll_reconfig_pkg.sv ***
// Constants, carriers and state codes for the synthesiser reconfiguration block
package pll_reconfig_pkg;

  // Settings chain layout, bit 0 is the first bit shifted in
  localparam int CHAIN_BITS = 144;
  localparam int SEG_BITS = 18;
  localparam int NUM_SEGS = 7;
  localparam int SEG_C4 = 0;
  localparam int SEG_C0 = 4;
  localparam int SEG_FB = 5;
  localparam int SEG_PRE = 6;
  localparam int SEG_LOW_LSB = 0;
  localparam int SEG_SKIP = 8;
  localparam int SEG_HIGH_LSB = 9;
  localparam int SEG_HALF = 17;
  localparam int CNT_BITS = 8;
  localparam int PUMP_LSB = 126;
  localparam int PUMP_BITS = 3;
  localparam int FILT_LSB = 135;
  localparam int FILT_RES_LSB = 135;
  localparam int FILT_RES_BITS = 5;
  localparam int FILT_CAP_LSB = 140;
  localparam int FILT_CAP_BITS = 2;

  // Phase taps: index 0..4 output counters zero..four, index 5 feedback
  localparam int TAP_BITS = 3;
  localparam int NUM_TAPS = 6;
  localparam int NUM_OUT_CNT = 5;
  localparam int TAP_FB = 5;
  localparam logic [2:0] TGT_ALL = 3'h0;
  localparam logic [2:0] TGT_FB = 3'h1;
  localparam logic [2:0] TGT_C0 = 3'h2;

  // Register map and values after reset
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TAPS = 8'h08;
  localparam logic [7:0] ADDR_CFG0 = 8'h0c;
  localparam logic [7:0] ADDR_CFG1 = 8'h10;
  localparam logic [7:0] ADDR_CFG2 = 8'h14;
  localparam logic [7:0] ADDR_CFG3 = 8'h18;
  localparam logic [7:0] ADDR_CFG4 = 8'h1c;
  localparam logic [7:0] APPLY_CYCLES_RST = 8'h08;
  localparam logic [7:0] STEP_CYCLES_RST = 8'h02;
  localparam int CTRL_APPLY_LSB = 0;
  localparam int CTRL_STEP_LSB = 8;

  // Reconfiguration link as seen at the pins
  typedef struct packed {
    logic recfg_clk;
    logic shift_enable;
    logic serial_setting_in;
    logic apply_settings;
    logic phase_step_request;
    logic phase_direction;
    logic [2:0] phase_target_select;
  } link_in_s;

  // Effective counter timing in half VCO cycles
  typedef struct packed {
    logic bypass;
    logic [8:0] high_half;
    logic [8:0] low_half;
  } cnt_eff_s;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_WAIT1 = 2'b01,
    PH_WAIT2 = 2'b11,
    PH_BUSY = 2'b10
  } phase_state_e;

endpackage : pll_reconfig_pkg

// *** testbench/link_ctrl_model.sv ***
// Reconfiguration controller model driving the link pins
`timescale 1ns/1ps
`default_nettype none

module link_ctrl_model
  import pll_reconfig_pkg::*;
(
  // Link toward the block
  output var link_in_s link,
  input wire logic phase_step_complete
);
  logic clk_r = 1'b0;
  logic seen_low = 1'b0;
  link_in_s pins = '0;

  // Runs free, the step handshake is timed on it
  always #80 clk_r = ~clk_r;
  // Complete may stay low for less than one link cycle
  always @(negedge phase_step_complete) seen_low = 1'b1;

  always_comb begin
    link = pins;
    link.recfg_clk = clk_r;
  end

  task automatic shift_chain(input logic [CHAIN_BITS-1:0] bits);
    @(negedge clk_r) pins.shift_enable <= 1'b1;
    for (int i = 0; i < CHAIN_BITS; i++) begin
      @(negedge clk_r) pins.serial_setting_in <= bits[i];
    end
    @(negedge clk_r) begin
      pins.shift_enable <= 1'b0;
      pins.serial_setting_in <= ~bits[CHAIN_BITS-1];
    end
    @(negedge clk_r) pins.apply_settings <= 1'b1;
    @(negedge clk_r) pins.apply_settings <= 1'b0;
  endtask : shift_chain

  task automatic phase_step(input logic dir, input logic [2:0] tgt,
                            input int extra, output logic ok);
    @(posedge clk_r) begin
      pins.phase_direction <= dir;
      pins.phase_target_select <= tgt;
      seen_low = 1'b0;
    end
    @(posedge clk_r) pins.phase_step_request <= 1'b1;
    repeat (2) @(posedge clk_r);
    for (int i = 0; i < 8 && !seen_low; i++) @(posedge clk_r);
    repeat (extra) @(posedge clk_r);
    pins.phase_step_request <= 1'b0;
    for (int i = 0; i < 8 && phase_step_complete !== 1'b1; i++) begin
      @(posedge clk_r);
    end
    ok = seen_low && (phase_step_complete === 1'b1);
    @(posedge clk_r);
  endtask : phase_step
endmodule : link_ctrl_model

`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench: APB registers, settings chain, phase steps
`timescale 1ns/1ps
`default_nettype none

module testbench import pll_reconfig_pkg::*;;
  typedef struct packed {
    logic dir;
    logic [2:0] tgt;
    logic [17:0] taps;
  } row_s;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  link_in_s link;
  logic step_done;
  logic apply_busy;
  logic [NUM_TAPS-1:0][TAP_BITS-1:0] phase_tap;
  cnt_eff_s [NUM_SEGS-1:0] counter_eff;
  int miscompares = 0;
  int comparisons = 0;
  logic apply_seen = 1'b0;
  logic [CHAIN_BITS-1:0] chain;
  logic [31:0] rd;
  logic err;
  logic ok;
  // Last row wraps output taps zero, two and four below zero
  row_s rows [9] = '{
    '{1'b1, 3'h0, 18'h01249}, '{1'b1, 3'h1, 18'h09249},
    '{1'b0, 3'h2, 18'h09248}, '{1'b1, 3'h3, 18'h09250},
    '{1'b0, 3'h4, 18'h09210}, '{1'b1, 3'h5, 18'h09410},
    '{1'b0, 3'h6, 18'h08410}, '{1'b1, 3'h7, 18'h08410},
    '{1'b0, 3'h0, 18'h0f3cf}};

  pll_reconfig dut_u (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link), .phase_step_complete(step_done),
    .apply_in_progress(apply_busy), .phase_tap(phase_tap),
    .counter_eff(counter_eff));
  link_ctrl_model link_u (.link(link), .phase_step_complete(step_done));

  always #10 pclk = ~pclk;
  always @(posedge apply_busy) apply_seen = 1'b1;

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge pclk) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
    end
    @(posedge pclk) penable <= 1'b1;
    // Ready, data and error are taken at the edge that ends the access
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("MISMATCH %0t apb access never ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic load(input logic [CHAIN_BITS-1:0] c);
    apply_seen = 1'b0;
    link_u.shift_chain(c);
    for (int i = 0; i < 40 && !(apply_seen && apply_busy === 1'b0); i++) begin
      @(negedge pclk);
    end
    check({30'h0, apply_seen, apply_busy}, 32'h2, "apply busy");
  endtask : load

  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h00000208, "ctrl reset");
    apb(1'b1, ADDR_CTRL, 32'h00000304);
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h00000304, "ctrl rw");
    apb(1'b1, ADDR_STATUS, 32'hf);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h2, "status ro");
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped err");
    check(rd, 32'h0, "unmapped data");
    $display("test registers done");
    chain = '0;
    chain[SEG_C4*SEG_BITS +: SEG_BITS] = {1'b1, 8'h05, 1'b0, 8'h03};
    chain[SEG_C0*SEG_BITS +: SEG_BITS] = {1'b0, 8'h06, 1'b0, 8'h04};
    chain[SEG_PRE*SEG_BITS +: SEG_BITS] = {1'b1, 8'h33, 1'b1, 8'h55};
    chain[PUMP_LSB +: PUMP_BITS] = 3'h3;
    chain[FILT_RES_LSB +: FILT_RES_BITS] = 5'h13;
    chain[FILT_CAP_LSB +: FILT_CAP_BITS] = 2'h3;
    chain[CHAIN_BITS-1] = 1'b1;
    load(chain);
    check({13'h0, counter_eff[SEG_C4]}, 32'h1207, "out4");
    check({13'h0, counter_eff[SEG_C0]}, 32'h1808, "out0");
    check({31'h0, counter_eff[SEG_PRE].bypass}, 32'h1, "skip");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ADDR_CFG0 + 8'(4 * i), 32'h0);
      check(rd, i < 4 ? chain[32*i +: 32] : {16'h0, chain[143:128]},
            "cfg");
    end
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h2, "legal codes");
    for (int k = 0; k < 3; k++) begin
      chain[PUMP_LSB +: PUMP_BITS] = k == 0 ? 3'h2 : 3'h3;
      chain[FILT_RES_LSB +: FILT_RES_BITS] = k == 1 ? 5'h01 : 5'h13;
      chain[FILT_CAP_LSB +: FILT_CAP_BITS] = k == 2 ? 2'h2 : 2'h3;
      load(chain);
      apb(1'b0, ADDR_STATUS, 32'h0);
      check(rd, 32'h6, "illegal code");
    end
    $display("test chain done");
    foreach (rows[r]) begin
      link_u.phase_step(rows[r].dir, rows[r].tgt, 0, ok);
      check({31'h0, ok}, 32'h1, "handshake");
      check({14'h0, phase_tap}, {14'h0, rows[r].taps}, "taps");
    end
    link_u.phase_step(1'b1, TGT_FB, 6, ok);
    check({31'h0, ok}, 32'h1, "held handshake");
    check({14'h0, phase_tap}, 32'h173cf, "held request");
    apb(1'b0, ADDR_TAPS, 32'h0);
    check(rd, 32'h173cf, "taps reg");
    apb(1'b0, ADDR_CFG0, 32'h0);
    check(rd, chain[31:0], "chain kept");
    // Frozen block must neither answer nor step
    ce <= 1'b0;
    link_u.phase_step(1'b1, TGT_FB, 0, ok);
    check({31'h0, ok}, 32'h0, "frozen step");
    check({14'h0, phase_tap}, 32'h173cf, "frozen taps");
    @(posedge pclk) ce <= 1'b1;
    $display("test phase done");
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    check({14'h0, phase_tap}, 32'h0, "taps reset");
    check({31'h0, step_done}, 32'h1, "complete reset");
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({29'h0, pready, apply_busy, step_done}, 32'h1, "after reset");
    $display("test reset done");
    stop_test();
  end

  // Four chain loads and eleven steps need about 115 us
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule : testbench

`default_nettype wire
